// ---- src/ubam_pkg.sv ----
// Shared constants for the channel-2 break address match block.
//
// Contract
// R1 - 32-bit readable writable break address register
// R2 - Compare against one of three buses
// R3 - Power-on reset clears; other resets keep
// R4 - Fetch cycle matches fetch address bits 31:0
// R5 - Data cycle matches data access address
// R6 - Software clears address LSB for fetch breaks
// R7 - Write lands late; read-back confirms it
// R8 - One channel watches only one bus group
// R9 - Higher priority exception suppresses user break
// R10 - Delay slot pre-break deferred to target
// R11 - Module standby generates no breaks
// R12 - No break addresses in level-15 handlers
// R13 - No post-break on sleep instruction
// R14 - Lower-half pre-break becomes post-break
// R15 - Break after suspended divide still fires
// R16 - Post channel flags set despite pre-break
// R17 - Match sets flag and requests break
package ubam_pkg;

  // Register geometry and reset value.
  localparam int ADDR_W = 32;
  localparam logic [31:0] BREAK_ADDR_RESET = 32'h00000000;

  // Encoding of the two bus select bits, hi bit first.
  localparam logic [1:0] BUS_SEL_NONE = 2'h0;
  localparam logic [1:0] BUS_SEL_CPU = 2'h1;
  localparam logic [1:0] BUS_SEL_PERIPH = 2'h2;
  localparam logic [1:0] BUS_SEL_RSVD = 2'h3;

  // Cycle kind on the processor side bus.
  localparam logic CYCLE_FETCH = 1'b0;
  localparam logic CYCLE_DATA = 1'b1;

endpackage

// ---- src/ubam_cmp.sv ----
// Address equality comparator with a qualifying strobe.
`timescale 1ns/100ps
module ubam_cmp #(
  parameter int W = 32
) (
  input wire logic valid_i,
  input wire logic [W-1:0] addr_i,
  input wire logic [W-1:0] ref_i,
  output logic hit_o
);

  // Full-width compare; no mask exists for this channel.
  assign hit_o = valid_i && (addr_i == ref_i);

endmodule // ubam_cmp

// ---- src/ubam_top.sv ----
// Channel-2 break address register and address match logic.
`timescale 1ns/100ps
module ubam_top #(
  parameter int ADDR_W = ubam_pkg::ADDR_W
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic manual_reset_i,
  input wire logic module_standby_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [ADDR_W-1:0] reg_wdata_i,
  output logic [ADDR_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic bus_select_bit_hi_i,
  input wire logic bus_select_bit_lo_i,
  input wire logic cycle_kind_i,
  input wire logic pre_exec_i,
  input wire logic fetch_valid_i,
  input wire logic [ADDR_W-1:0] instruction_fetch_address_bus_i,
  input wire logic fetch_lower_half_i,
  input wire logic fetch_in_slot_i,
  input wire logic data_valid_i,
  input wire logic [ADDR_W-1:0] data_access_address_bus_i,
  input wire logic periph_valid_i,
  input wire logic [ADDR_W-1:0] peripheral_side_address_bus_i,
  input wire logic higher_exc_i,
  input wire logic flag_clr_i,
  output logic match_flag_o,
  output logic break_req_o,
  output logic break_post_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check.

  // The register, its reset value and the read path are all one word wide.
  // Any other width would need a byte-lane write scheme that is not built.
  if (ADDR_W != 32) begin : g_bad_width
    $error("ubam_top supports only a 32-bit break address");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [ADDR_W-1:0] break_address_ch2;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_data;
    logic rd_pend;
    logic [ADDR_W-1:0] rdata;
    logic rvalid;
    logic flag;
    logic req;
    logic post;
    logic deferred;
  } ubam_state_t;

  ubam_state_t st;
  ubam_state_t next_st;

  logic [1:0] bus_sel;
  logic hit_fetch;
  logic hit_data;
  logic hit_periph;
  logic fetch_en;
  logic data_en;
  logic periph_en;

  assign bus_sel = {bus_select_bit_hi_i, bus_select_bit_lo_i};

  // R8 one bus group
  // Only the selected group's strobes reach a comparator.
  assign fetch_en = fetch_valid_i && (bus_sel == ubam_pkg::BUS_SEL_CPU) &&
                    (cycle_kind_i == ubam_pkg::CYCLE_FETCH);
  assign data_en = data_valid_i && (bus_sel == ubam_pkg::BUS_SEL_CPU) &&
                   (cycle_kind_i == ubam_pkg::CYCLE_DATA);
  assign periph_en = periph_valid_i && (bus_sel == ubam_pkg::BUS_SEL_PERIPH);

  ////////////////////////////////////////////////////////////////////////////
  // Comparators, one per watched bus.

  // R4 full fetch compare
  ubam_cmp #(.W(ADDR_W)) u_cmp_fetch (
    .valid_i(fetch_en),
    .addr_i(instruction_fetch_address_bus_i),
    .ref_i(st.break_address_ch2),
    .hit_o(hit_fetch)
  );

  // R5 data access compare
  ubam_cmp #(.W(ADDR_W)) u_cmp_data (
    .valid_i(data_en),
    .addr_i(data_access_address_bus_i),
    .ref_i(st.break_address_ch2),
    .hit_o(hit_data)
  );

  // R2 peripheral bus compare
  ubam_cmp #(.W(ADDR_W)) u_cmp_periph (
    .valid_i(periph_en),
    .addr_i(peripheral_side_address_bus_i),
    .ref_i(st.break_address_ch2),
    .hit_o(hit_periph)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    logic fire;
    logic fire_post;
    fire = 1'b0;
    fire_post = 1'b0;
    next_st = st;
    next_st.req = 1'b0;
    next_st.post = 1'b0;
    next_st.rvalid = 1'b0;

    // R7 delayed write commit
    // A write is staged for one cycle, so a break may be missed meanwhile.
    if (st.wr_pend) begin
      next_st.break_address_ch2 = st.wr_data;
      next_st.wr_pend = 1'b0;
    end
    if (reg_wr_i && !module_standby_i) begin
      next_st.wr_pend = 1'b1;
      next_st.wr_data = reg_wdata_i;
    end

    // R7 read after commit
    // A read waits out any staged write so it returns the live value.
    if (reg_rd_i && !module_standby_i) begin
      next_st.rd_pend = 1'b1;
    end
    if ((st.rd_pend || (reg_rd_i && !module_standby_i)) && !st.wr_pend &&
        !(reg_wr_i && !module_standby_i)) begin
      next_st.rd_pend = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = st.break_address_ch2;
    end

    // R10 deferred slot break
    // A pre-break in a delay slot fires at the first non-slot fetch.
    if (st.deferred && fetch_valid_i && !fetch_in_slot_i) begin
      fire = 1'b1;
      next_st.deferred = 1'b0;
    end

    if (hit_fetch) begin
      // R14 lower half post
      if (!pre_exec_i || fetch_lower_half_i) begin
        fire = 1'b1;
        fire_post = 1'b1;
      end else if (fetch_in_slot_i) begin
        next_st.deferred = 1'b1;
      end else begin
        // R15 divide not checked
        // Suspension of a preceding divide does not cancel the break.
        fire = 1'b1;
      end
    end
    // R16 post flag independent
    // Data and peripheral matches are reported after the access.
    if (hit_data || hit_periph) begin
      fire = 1'b1;
      fire_post = 1'b1;
    end

    // R9 higher exception suppresses
    if (higher_exc_i) begin
      fire = 1'b0;
    end

    // R11 standby no breaks
    if (module_standby_i) begin
      fire = 1'b0;
      next_st.deferred = 1'b0;
    end

    // R17 flag and request
    // Set wins over a clear arriving in the same cycle.
    if (flag_clr_i) begin
      next_st.flag = 1'b0;
    end
    if (fire) begin
      next_st.flag = 1'b1;
      next_st.req = 1'b1;
      next_st.post = fire_post;
    end

    // R3 manual reset keeps
    // Manual reset drops only in-flight events, never the address.
    if (manual_reset_i) begin
      next_st.deferred = 1'b0;
      next_st.req = 1'b0;
      next_st.post = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // R1 break address storage
  // R3 power-on clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
      st.break_address_ch2 <= ubam_pkg::BREAK_ADDR_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a state bit, so nothing combinational leaves the block.
  assign reg_rdata_o = st.rdata;
  assign reg_rvalid_o = st.rvalid;
  assign match_flag_o = st.flag;
  assign break_req_o = st.req;
  assign break_post_o = st.post;

endmodule // ubam_top

// ---- dv/ubam_asserts.sv ----
// Port checker for the break address match block.
`timescale 1ns/100ps
module ubam_asserts (
  input wire logic clk_i, nrst_i, manual_reset_i, module_standby_i,
  input wire logic reg_wr_i, reg_rvalid_o, cycle_kind_i, higher_exc_i,
  input wire logic bus_select_bit_hi_i, bus_select_bit_lo_i, flag_clr_i,
  input wire logic fetch_valid_i, fetch_lower_half_i, fetch_in_slot_i,
  input wire logic data_valid_i, match_flag_o, break_req_o, break_post_o,
  input wire logic pre_exec_i,
  input wire logic [31:0] reg_wdata_i, reg_rdata_o,
  input wire logic [31:0] instruction_fetch_address_bus_i,
  input wire logic [31:0] data_access_address_bus_i
);
  logic [32:0] stg;
  logic [31:0] live;
  logic ok;
  logic lh;
  // Mirror of the staged write; the address goes live two edges later.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stg <= '0;
      live <= '0;
      lh <= 1'b0;
    end else begin
      stg <= {reg_wr_i & ~module_standby_i, reg_wdata_i};
      if (stg[32]) live <= stg[31:0];
      lh <= ok && fetch_valid_i && fetch_lower_half_i && !cycle_kind_i &&
        instruction_fetch_address_bus_i == live;
    end
  end
  // Processor bus watched and nothing blocking an event.
  assign ok = {bus_select_bit_hi_i, bus_select_bit_lo_i} ==
    ubam_pkg::BUS_SEL_CPU && !module_standby_i && !higher_exc_i &&
    !manual_reset_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Break events, flags and read answers.
  flag_on_req_a: assert property (break_req_o |-> match_flag_o)
    else $error("break without flag");
  flag_hold_a: assert property (
    match_flag_o && !flag_clr_i |=> match_flag_o) else $error("flag lost");
  fetch_hit_a: assert property (ok && fetch_valid_i && !cycle_kind_i &&
    !fetch_in_slot_i && instruction_fetch_address_bus_i == live
    |=> break_req_o) else $error("fetch match missed");
  data_hit_a: assert property (ok && data_valid_i && cycle_kind_i &&
    data_access_address_bus_i == live |=> break_req_o && break_post_o)
    else $error("data match missed");
  low_half_a: assert property (
    lh |-> break_req_o && break_post_o) else $error("lower half not post");
  slot_hold_a: assert property (ok && fetch_valid_i && !cycle_kind_i &&
    pre_exec_i && fetch_in_slot_i && !fetch_lower_half_i &&
    instruction_fetch_address_bus_i == live |=> !break_req_o)
    else $error("slot break not deferred");
  standby_quiet_a: assert property (
    module_standby_i |=> !break_req_o) else $error("break in standby");
  exc_wins_a: assert property (
    higher_exc_i |=> !break_req_o) else $error("break not suppressed");
  read_value_a: assert property (
    reg_rvalid_o |-> reg_rdata_o == live) else $error("stale read");
  cover property (break_req_o && !break_post_o);
  cover property (break_req_o && break_post_o);
  cover property (reg_rvalid_o);
endmodule // ubam_asserts
bind ubam_top ubam_asserts u_ubam_asserts (.*);

// ---- dv/ubam_cpu.sv ----
// Processor side model driving the fetch and data address buses.
`timescale 1ns/100ps
module ubam_cpu (
  input wire logic clk_i,
  output logic fv_o,
  output logic dv_o,
  output logic [31:0] fa_o,
  output logic [31:0] da_o
);
  initial begin
    {fv_o, dv_o, fa_o, da_o} = '0;
  end
  // One access; a released bus shows the inverse so no value lingers.
  task automatic go(input logic d, input logic [31:0] a);
    @(negedge clk_i);
    if (d) {dv_o, da_o} = {1'h1, a};
    else {fv_o, fa_o} = {1'h1, a};
    @(negedge clk_i);
    {fv_o, dv_o} = 2'h0;
    fa_o = ~fa_o;
    da_o = ~da_o;
  endtask
endmodule // ubam_cpu

// ---- dv/tb.sv ----
// Self-checking bench for the break address match block.
`timescale 1ns/100ps
module tb;
  logic clk_i, nrst_i, manual_reset_i, module_standby_i, reg_wr_i, reg_rd_i;
  logic bus_select_bit_hi_i, bus_select_bit_lo_i, cycle_kind_i, pre_exec_i;
  logic fetch_valid_i, fetch_lower_half_i, fetch_in_slot_i, data_valid_i;
  logic periph_valid_i, higher_exc_i, flag_clr_i, reg_rvalid_o;
  logic match_flag_o, break_req_o, break_post_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, instruction_fetch_address_bus_i;
  logic [31:0] data_access_address_bus_i, peripheral_side_address_bus_i;
  localparam logic [31:0] A = 32'h8000ABC4;
  int n_fail, num_checks;
  ubam_top u_ubam_top (.*);
  ubam_cpu u_ubam_cpu (.clk_i, .fv_o(fetch_valid_i), .dv_o(data_valid_i),
    .fa_o(instruction_fetch_address_bus_i),
    .da_o(data_access_address_bus_i));
  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rd32(input logic [31:0] e);
    @(negedge clk_i) reg_rd_i = 1'h1;
    @(negedge clk_i) reg_rd_i = 1'h0;
    for (int i = 0; i < 8 && reg_rvalid_o !== 1'h1; i++) @(negedge clk_i);
    chk(reg_rvalid_o, 32'h1);
    chk(reg_rdata_o, e);
  endtask
  task automatic wr32(input logic [31:0] d);
    @(negedge clk_i) {reg_wr_i, reg_wdata_i} = {1'h1, d};
    @(negedge clk_i) reg_wr_i = 1'h0;
  endtask
  task automatic hit(input logic d, a_hi, input logic e, p);
    u_ubam_cpu.go(d, a_hi ? A ^ 32'h80000000 : A);
    chk(break_req_o, e);
    if (e) chk(break_post_o, p);
  endtask
  // Reset value, write, read-back and a manual reset that keeps it.
  task automatic t_reg;
    rd32(32'h0);
    wr32(A);
    rd32(A);
    @(negedge clk_i) manual_reset_i = 1'h1;
    @(negedge clk_i) manual_reset_i = 1'h0;
    rd32(A);
    @(negedge clk_i) nrst_i = 1'h0;
    @(negedge clk_i) nrst_i = 1'h1;
    rd32(32'h0);
    wr32(A);
    rd32(A);
    $display("t_reg done");
  endtask
  // Fetch and data matches on the processor bus and the conditions that block them.
  task automatic t_match;
    {bus_select_bit_lo_i, pre_exec_i} = 2'h3;
    hit(1'h0, 1'h0, 1'h1, 1'h0);
    hit(1'h0, 1'h1, 1'h0, 1'h0);
    fetch_lower_half_i = 1'h1;
    hit(1'h0, 1'h0, 1'h1, 1'h1);
    {fetch_lower_half_i, higher_exc_i} = 2'h1;
    hit(1'h0, 1'h0, 1'h0, 1'h0);
    {higher_exc_i, module_standby_i} = 2'h1;
    hit(1'h0, 1'h0, 1'h0, 1'h0);
    module_standby_i = 1'h0;
    {bus_select_bit_hi_i, bus_select_bit_lo_i} = 2'h2;
    hit(1'h0, 1'h0, 1'h0, 1'h0);
    {bus_select_bit_hi_i, bus_select_bit_lo_i, cycle_kind_i} = 3'h3;
    hit(1'h1, 1'h0, 1'h1, 1'h1);
    $display("t_match done");
  endtask
  // A slot pre-break waits for the first fetch outside the slot.
  task automatic t_slot;
    {cycle_kind_i, bus_select_bit_lo_i, pre_exec_i} = 3'h3;
    fetch_in_slot_i = 1'h1;
    hit(1'h0, 1'h0, 1'h0, 1'h0);
    fetch_in_slot_i = 1'h0;
    hit(1'h0, 1'h1, 1'h1, 1'h0);
    $display("t_slot done");
  endtask
  // Flag clear, then a peripheral match whose set beats a clear.
  task automatic t_periph;
    {bus_select_bit_hi_i, bus_select_bit_lo_i} = 2'h2;
    @(negedge clk_i) flag_clr_i = 1'h1;
    @(negedge clk_i) flag_clr_i = 1'h0;
    chk(match_flag_o, 32'h0);
    @(negedge clk_i) {periph_valid_i, flag_clr_i} = 2'h3;
    peripheral_side_address_bus_i = A;
    @(negedge clk_i) {periph_valid_i, flag_clr_i} = 2'h0;
    chk(break_req_o, 32'h1);
    chk(break_post_o, 32'h1);
    chk(match_flag_o, 32'h1);
    $display("t_periph done");
  endtask
  initial begin
    {nrst_i, manual_reset_i, module_standby_i, reg_wr_i, reg_rd_i} = '0;
    {bus_select_bit_hi_i, bus_select_bit_lo_i, cycle_kind_i} = '0;
    {pre_exec_i, fetch_lower_half_i, fetch_in_slot_i, higher_exc_i} = '0;
    {periph_valid_i, flag_clr_i, reg_wdata_i} = '0;
    peripheral_side_address_bus_i = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (2) @(negedge clk_i);
    nrst_i = 1'h1;
    t_reg;
    t_match;
    t_slot;
    t_periph;
    stop_test;
  end
  // The tests need well under 100 cycles; 1000 cycles means a hang.
  initial begin
    #4000;
    n_fail++;
    stop_test;
  end
endmodule // tb
